// ===== core/arr_consts.vh
// register map, field positions and codes for the result/trigger block
`ifndef ARR_CONSTS_VH
`define ARR_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define ARR_IDX_RES_LO   8'h78
`define ARR_IDX_RES_HI   8'h79
`define ARR_IDX_TRIG     8'h7b
`define ARR_IDX_DIDR     8'h7e
`define ARR_IDX_CTRL     8'h70
`define ARR_IDX_STAT     8'h71

// control register fields
`define ARR_CTL_EN       0
`define ARR_CTL_AUTO     1
`define ARR_CTL_LEFT     2
`define ARR_CTL_DIFF     3
`define ARR_CTL_START    4
`define ARR_CTL_MASK     4'hf

// status register fields
`define ARR_STA_DONE     0
`define ARR_STA_LOCK     1

// trigger control fields
`define ARR_TRG_CMUX     6
`define ARR_TRG_SEL_HI   2
`define ARR_TRG_SEL_LO   0
`define ARR_TRG_MASK     8'h47

// trigger source codes
`define ARR_TS_FREE      3'h0
`define ARR_TS_ACMP      3'h1
`define ARR_TS_EXT0      3'h2
`define ARR_TS_T0CMPA    3'h3
`define ARR_TS_T0OVF     3'h4
`define ARR_TS_T1CMPB    3'h5
`define ARR_TS_T1OVF     3'h6
`define ARR_TS_T1CAP     3'h7

// reset values
`define ARR_RST_BYTE     8'h00
`define ARR_RST_CTRL     4'h0
`define ARR_RST_RES      10'h000
`define ARR_RST_WORD     32'h0000_0000

`endif

// ===== core/arr_result_fmt.v
// result layout: right or left justified 16-bit view of the stored value
`default_nettype none

module arr_result_fmt #(
	parameter RES_W = 10
) (
	input  wire [RES_W-1:0] res_i,
	input  wire             left_i,
	output reg  [15:0]      pair_o
);

	// layout follows the control bit live, not latched per conversion
	always @* begin
		if (left_i) begin
			pair_o = {res_i, {(16-RES_W){1'b0}}};
		end else begin
			pair_o = {{(16-RES_W){1'b0}}, res_i};
		end
	end

endmodule

`default_nettype wire

// ===== core/arr_trig_sel.v
// auto-trigger source select and rising-edge detect
`include "arr_consts.vh"
`default_nettype none

module arr_trig_sel (
	input  wire       mclk_i,
	input  wire       rst_n_i,
	input  wire [2:0] sel_i,
	input  wire       auto_en_i,
	input  wire       conv_en_i,
	input  wire [7:0] flags_i,
	output wire       hit_o
);

	reg        prev_q;
	reg  [2:0] sel_q;
	wire       now;
	wire       rise;
	wire       to_free;

	// flag index equals trigger code; bit 0 is the done flag
	assign now = flags_i[sel_i];

	// previous value of the muxed flag, so a source switch looks like an edge
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_q <= 1'b0;
			sel_q  <= `ARR_TS_FREE;
		end else begin
			prev_q <= now;
			sel_q  <= sel_i;
		end
	end

	assign rise    = now & ~prev_q;
	// entering free-running must not fire on an already set done flag
	assign to_free = (sel_i == `ARR_TS_FREE) && (sel_q != `ARR_TS_FREE);
	assign hit_o   = auto_en_i & conv_en_i & rise & ~to_free;

endmodule

`default_nettype wire

// ===== core/arr_regs.v
// converter result, trigger control and pin input-disable registers on APB
`include "arr_consts.vh"
`default_nettype none

// Summary of operation
// - result pair is read-only; low byte at index 0x78, high byte next.
// - a completed conversion loads the result pair unless it is locked or a low-byte read is in flight.
// - differential channel results are stored in two's complement.
// - reading the low byte locks the pair until the high byte is read.
// - justify cleared: result in bits 9:0, upper bits zero.
// - justify set: result in bits 15:6, low byte top bits hold 1:0.
// - comparator mux enable with converter off routes mux to comparator.
// - trigger source select ignored unless auto-trigger is enabled.
// - auto-trigger starts a conversion on the selected flag's rise.
// - switching from a cleared to a set source is an edge.
// - switching to free-running never fires by itself.
// - trigger codes 000 free-run through 111 timer1 capture.
// - an input-disable bit forces that pin's digital input to zero.
// - done flag sets when a conversion finishes, even when the locked pair is not updated.
// - justify changes the presented layout at once.
// - each positive trigger edge, except one made by switching to free-running, starts a conversion while both auto and the converter enable are on.
module arr_regs #(
	parameter RES_W = 10,
	parameter PINS  = 8
) (
	input  wire             mclk_i,
	input  wire             rst_n_i,
	// apb slave
	input  wire             psel_i,
	input  wire             penable_i,
	input  wire             pwrite_i,
	input  wire [11:0]      paddr_i,
	input  wire [31:0]      pwdata_i,
	input  wire [3:0]       pstrb_i,
	output wire             pready_o,
	output wire [31:0]      prdata_o,
	output wire             pslverr_o,
	// converter core
	input  wire             conv_done_i,
	input  wire [RES_W-1:0] conv_data_i,
	output wire             conv_start_o,
	output wire             conv_en_o,
	// trigger flags of the peripherals, index = trigger code, 0 unused
	input  wire [7:1]       trig_flags_i,
	// comparator negative input select: 1 = converter mux
	output wire             cmp_mux_sel_o,
	// analog pins
	input  wire [PINS-1:0]  pin_raw_i,
	output wire [PINS-1:0]  pin_in_o,
	output wire [PINS-1:0]  pin_buf_dis_o,
	// visible conversion-complete flag
	output wire             conv_done_flag_o
);

	reg             pready_q;
	reg  [31:0]     prdata_q;
	reg             pslverr_q;
	reg  [3:0]      ctrl_q;
	reg  [7:0]      trig_q;
	reg  [PINS-1:0] didr_q;
	reg  [RES_W-1:0] res_q;
	reg             lock_q;
	reg             done_q;
	reg             start_q;
	reg             cmp_q;
	reg  [PINS-1:0] pin_q;
	reg  [31:0]     rdata_d;
	reg             mapped_d;

	wire            setup;
	wire            acc;
	wire            wr;
	wire            rd;
	wire            hit_lo;
	wire            hit_hi;
	wire            hit_trig;
	wire            hit_didr;
	wire            hit_ctrl;
	wire            hit_stat;
	wire            lo_pending;
	wire            upd_ok;
	wire [RES_W-1:0] conv_val;
	wire [15:0]     pair;
	wire            trig_hit;
	wire            man_start;
	wire            done_clr;
	wire            ctl_en;
	wire            ctl_auto;
	wire            ctl_left;
	wire            ctl_diff;
	wire [2:0]      trg_sel;
	wire            trg_cmux;
	wire            rd_lo;
	wire            rd_hi;

	// byte address match for an index-based register
	function arr_hit;
		input [11:0] addr;
		input [7:0]  idx;
		begin
			arr_hit = (addr == {2'b00, idx, 2'b00});
		end
	endfunction

	// one byte of the presented pair, upper or lower half
	function [7:0] arr_byte;
		input [15:0] word;
		input        upper;
		begin
			arr_byte = upper ? word[15:8] : word[7:0];
		end
	endfunction

	// bus phase decode
	assign setup = psel_i & ~penable_i;
	assign acc   = psel_i & penable_i & pready_q;
	assign wr    = acc & pwrite_i & pstrb_i[0];
	assign rd    = acc & ~pwrite_i;

	// address decode
	assign hit_lo   = arr_hit(paddr_i, `ARR_IDX_RES_LO);
	assign hit_hi   = arr_hit(paddr_i, `ARR_IDX_RES_HI);
	assign hit_trig = arr_hit(paddr_i, `ARR_IDX_TRIG);
	assign hit_didr = arr_hit(paddr_i, `ARR_IDX_DIDR);
	assign hit_ctrl = arr_hit(paddr_i, `ARR_IDX_CTRL);
	assign hit_stat = arr_hit(paddr_i, `ARR_IDX_STAT);

	// control fields pulled out once, read in several places
	assign ctl_en   = ctrl_q[`ARR_CTL_EN];
	assign ctl_auto = ctrl_q[`ARR_CTL_AUTO];
	assign ctl_left = ctrl_q[`ARR_CTL_LEFT];
	assign ctl_diff = ctrl_q[`ARR_CTL_DIFF];
	assign trg_sel  = trig_q[`ARR_TRG_SEL_HI:`ARR_TRG_SEL_LO];
	assign trg_cmux = trig_q[`ARR_TRG_CMUX];
	assign rd_lo    = rd & hit_lo;
	assign rd_hi    = rd & hit_hi;

	// presented 16-bit layout of the stored result
	arr_result_fmt #(
		.RES_W (RES_W)
	) u_fmt (
		.res_i  (res_q),
		.left_i (ctl_left),
		.pair_o (pair)
	);

	// trigger source select and edge detect; code 0 watches the done flag
	arr_trig_sel u_trig (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n_i),
		.sel_i     (trg_sel),
		.auto_en_i (ctl_auto),
		.conv_en_i (ctl_en),
		.flags_i   ({trig_flags_i, done_q}),
		.hit_o     (trig_hit)
	);

	// read data mux; unmapped addresses read zero and flag an error
	always @* begin
		rdata_d  = `ARR_RST_WORD;
		mapped_d = 1'b1;
		if (hit_lo) begin
			rdata_d[7:0] = arr_byte(pair, 1'b0);
		end else if (hit_hi) begin
			rdata_d[7:0] = arr_byte(pair, 1'b1);
		end else if (hit_trig) begin
			rdata_d[7:0] = trig_q;
		end else if (hit_didr) begin
			rdata_d[PINS-1:0] = didr_q;
		end else if (hit_ctrl) begin
			rdata_d[3:0] = ctrl_q;
		end else if (hit_stat) begin
			rdata_d[`ARR_STA_DONE] = done_q;
			rdata_d[`ARR_STA_LOCK] = lock_q;
		end else begin
			mapped_d = 1'b0;
		end
	end

	// one wait-free answer: data latched in setup, pready in access
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_q  <= 1'b0;
			prdata_q  <= `ARR_RST_WORD;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped_d;
			if (setup) begin
				prdata_q <= pwrite_i ? `ARR_RST_WORD : rdata_d;
			end
		end
	end

	// writable registers; result pair has no write path at all
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `ARR_RST_CTRL;
			trig_q <= `ARR_RST_BYTE;
			didr_q <= {PINS{1'b0}};
		end else begin
			if (wr && hit_ctrl) begin
				ctrl_q <= pwdata_i[3:0] & `ARR_CTL_MASK;
			end
			if (wr && hit_trig) begin
				trig_q <= pwdata_i[7:0] & `ARR_TRG_MASK;
			end
			if (wr && hit_didr) begin
				didr_q <= pwdata_i[PINS-1:0];
			end
		end
	end

	// the lock must also cover a low-byte read still in flight,
	// else a late update could split the pair between two conversions
	assign lo_pending = psel_i & ~pwrite_i & hit_lo;
	assign upd_ok     = conv_done_i & ~lock_q & ~lo_pending;

	// differential core output is offset binary; flip msb for signed form
	assign conv_val = ctl_diff ?
		{~conv_data_i[RES_W-1], conv_data_i[RES_W-2:0]} :
		conv_data_i;

	// result store and read lock; writes never touch either
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			res_q  <= `ARR_RST_RES;
			lock_q <= 1'b0;
		end else begin
			if (upd_ok) begin
				res_q <= conv_val;
			end
			if (rd_lo) begin
				lock_q <= 1'b1;
			end else if (rd_hi) begin
				lock_q <= 1'b0;
			end
		end
	end

	// done flag: set on completion, cleared by writing one; set wins
	assign done_clr = wr & hit_stat & pwdata_i[`ARR_STA_DONE];

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= conv_done_i | (done_q & ~done_clr);
		end
	end

	// software start bit is a strobe, it is never stored
	assign man_start = wr & hit_ctrl & pwdata_i[`ARR_CTL_START] &
		pwdata_i[`ARR_CTL_EN];

	// start strobe to the core, one cycle per trigger
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_q <= 1'b0;
		end else begin
			start_q <= trig_hit | man_start;
		end
	end

	// comparator input routing: only while the converter is off
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmp_q <= 1'b0;
		end else begin
			cmp_q <= trg_cmux & ~ctl_en;
		end
	end

	// digital pin inputs read zero when their buffer is disabled
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_q <= {PINS{1'b0}};
		end else begin
			pin_q <= pin_raw_i & ~didr_q;
		end
	end

	// outputs, all straight from flops
	assign pready_o         = pready_q;
	assign prdata_o         = prdata_q;
	assign pslverr_o        = pslverr_q;
	assign conv_start_o     = start_q;
	assign conv_en_o        = ctl_en;
	assign cmp_mux_sel_o    = cmp_q;
	assign pin_in_o         = pin_q;
	assign pin_buf_dis_o    = didr_q;
	assign conv_done_flag_o = done_q;

endmodule

`default_nettype wire

// ===== testbench/arr_regs_properties.sv
// concurrent checks on the result/trigger register block ports
`default_nettype none
module arr_regs_props #(
	parameter PINS = 8
) (
	input wire logic            mclk_i,
	input wire logic            rst_n_i,
	input wire logic            psel_i,
	input wire logic            penable_i,
	input wire logic            pready_o,
	input wire logic            pslverr_o,
	input wire logic [31:0]     prdata_o,
	input wire logic            conv_done_i,
	input wire logic            conv_done_flag_o,
	input wire logic            conv_start_o,
	input wire logic            conv_en_o,
	input wire logic            cmp_mux_sel_o,
	input wire logic [PINS-1:0] pin_in_o,
	input wire logic [PINS-1:0] pin_buf_dis_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// bus answer is zero-wait and a single pulse
	ready_setup_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("ready missing after setup");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i))
		else $error("ready without setup");
	err_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 0)
		else $error("error response malformed");
	rdata_upper_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	// converter and trigger side
	done_flag_a: assert property (conv_done_i |=> conv_done_flag_o)
		else $error("done flag not set");
	start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
		else $error("start longer than one cycle");
	cmp_mux_off_a: assert property (cmp_mux_sel_o |-> !$past(conv_en_o))
		else $error("comparator mux with converter on");
	pin_gate_a: assert property ((pin_in_o & $past(pin_buf_dis_o)) == 0)
		else $error("disabled pin reads one");

	cover property (conv_start_o);
	cover property (pslverr_o);
	cover property (cmp_mux_sel_o);
endmodule

bind arr_regs arr_regs_props #(.PINS(PINS)) u_props (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.prdata_o(prdata_o), .conv_done_i(conv_done_i),
	.conv_done_flag_o(conv_done_flag_o), .conv_start_o(conv_start_o),
	.conv_en_o(conv_en_o), .cmp_mux_sel_o(cmp_mux_sel_o),
	.pin_in_o(pin_in_o), .pin_buf_dis_o(pin_buf_dis_o)
);
`default_nettype wire

// ===== testbench/arr_conv_model.sv
// behavioural converter core: answers a start after lat_i cycles; a new start restarts the count
`default_nettype none
module arr_conv_model (
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [3:0] lat_i,
	input  wire logic [9:0] val_i,
	output var  logic       done_o,
	output var  logic [9:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic [9:0] last_q;

	// idle data bus shows the inverse of the last result, never a copy
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 4'h0;
			done_o <= 1'b0;
			data_o <= 10'h000;
			last_q <= 10'h000;
		end else begin
			done_o <= (cnt_q == 4'h1);
			cnt_q <= start_i ? lat_i : (cnt_q != 0 ? cnt_q - 4'h1 : 4'h0);
			data_o <= (cnt_q == 4'h1) ? val_i : ~last_q;
			if (cnt_q == 4'h1)
				last_q <= val_i;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/tb_adc_result_and_trigger_regs.sv
// self-checking bench: apb tasks, converter model, scenario sequence
`default_nettype none
`include "arr_consts.vh"
module tb_adc_result_and_trigger_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] LO = `ARR_IDX_RES_LO, HI = `ARR_IDX_RES_HI;
	localparam logic [7:0] TR = `ARR_IDX_TRIG, DI = `ARR_IDX_DIDR;
	localparam logic [7:0] CT = `ARR_IDX_CTRL, ST = `ARR_IDX_STAT;
	logic        mclk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  pstrb = 4'hf, lat = 4'h3;
	logic        pready, perr, er, done, start, en, cmux, dflag;
	logic [9:0]  cdata, val = 0;
	logic [7:1]  flags = 0;
	logic [7:0]  raw = 0, pin_in, dis;
	int          failures = 0, compares = 0, starts = 0, n;

	arr_regs DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(perr), .conv_done_i(done),
		.conv_data_i(cdata), .conv_start_o(start), .conv_en_o(en),
		.trig_flags_i(flags), .cmp_mux_sel_o(cmux), .pin_raw_i(raw),
		.pin_in_o(pin_in), .pin_buf_dis_o(dis), .conv_done_flag_o(dflag));
	arr_conv_model core (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.start_i(start), .lat_i(lat), .val_i(val), .done_o(done),
		.data_o(cdata));

	// clock and start-pulse counter
	initial forever #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (start === 1'b1) starts <= starts + 1;

	task automatic give_verdict();
		if (failures == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; an idle edge follows so psel is never reassigned
	task automatic apb(input logic w, input logic [7:0] i,
		input logic [31:0] d);
		int k;
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge mclk_i);
		pen <= 1;
		k = 0;
		do begin
			@(posedge mclk_i);
			k++;
		end while (pready !== 1'b1 && k < 10);
		if (k >= 10) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		er = perr;
		psel <= 0;
		pen <= 0;
		@(posedge mclk_i);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1, i, {24'h0, d});
	endtask
	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		apb(0, i, 0);
		chk(rd, {24'h0, e});
	endtask
	// manual start; the done flag is cleared first, then awaited
	task automatic conv(input logic [9:0] v, input logic [7:0] c);
		val <= v;
		wr(ST, 8'h01);
		wr(CT, c | 8'h11);
		n = 0;
		while (dflag !== 1'b1 && n < 20) begin
			@(posedge mclk_i);
			n++;
		end
		chk(n < 20, 1);
		if (n >= 20) give_verdict();
	endtask
	// auto-trigger: raise the flag of code c and count starts
	task automatic fire(input int c, input int e);
		n = starts;
		flags[c] <= 1;
		repeat (4) @(posedge mclk_i);
		chk(starts - n, e);
		flags[c] <= 0;
	endtask

	initial begin
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1;
		@(posedge mclk_i);
		rdc(TR, 8'h00);
		rdc(DI, 8'h00);
		rdc(LO, 8'h00);
		rdc(HI, 8'h00);
		conv(10'h2a5, 8'h00);
		rdc(LO, 8'ha5);
		rdc(HI, 8'h02);
		wr(CT, 8'h05);
		rdc(LO, 8'h40);
		rdc(HI, 8'ha9);
		conv(10'h155, 8'h04);
		rdc(HI, 8'h55);
		rdc(LO, 8'h40);
		conv(10'h0ff, 8'h04);
		rdc(HI, 8'h55);
		rdc(LO, 8'h40);
		wr(LO, 8'hff);
		chk(er, 0);
		wr(HI, 8'hff);
		rdc(ST, 8'h03);
		conv(10'h3ff, 8'h04);
		rdc(HI, 8'h55);
		conv(10'h3ff, 8'h04);
		rdc(HI, 8'hff);
		lat <= 4'h9;
		conv(10'h3ff, 8'h08);
		rdc(LO, 8'hff);
		rdc(HI, 8'h01);
		rdc(CT, 8'h09);
		apb(0, 8'h40, 0);
		chk({31'h0, er}, 1);
		chk(rd, 0);
		wr(CT, 8'h01);
		wr(TR, 8'h02);
		fire(2, 0);
		wr(CT, 8'h03);
		for (int c = 1; c < 8; c++) begin
			wr(TR, 8'(c));
			fire(c, 1);
		end
		wr(TR, 8'h01);
		n = starts;
		wr(TR, 8'h00);
		repeat (3) @(posedge mclk_i);
		chk(starts - n, 0);
		wr(TR, 8'h01);
		flags[3] <= 1;
		n = starts;
		wr(TR, 8'h03);
		repeat (3) @(posedge mclk_i);
		chk(starts - n, 1);
		flags[3] <= 0;
		wr(CT, 8'h01);
		wr(TR, 8'hff);
		rdc(TR, 8'h47);
		chk(en, 1);
		chk(cmux, 0);
		wr(CT, 8'h00);
		repeat (2) @(posedge mclk_i);
		chk(en, 0);
		chk(cmux, 1);
		pstrb <= 4'h0;
		wr(TR, 8'h00);
		pstrb <= 4'hf;
		rdc(TR, 8'h47);
		raw <= 8'hff;
		wr(DI, 8'h0f);
		repeat (2) @(posedge mclk_i);
		chk({dis, pin_in}, 16'h0ff0);
		rdc(DI, 8'h0f);
		give_verdict();
	end
endmodule
`default_nettype wire
